// >>> transceiver_mode_control.sv
// Power modes, register storage and operating_config decode of the transceiver
`timescale 1ns/1ps
`include "trx_params.svh"

// Function
// RQ1: From OFF, power-on high or push button low wakes the device to IDLE.
// RQ2: Waking raises the interrupt and sets the flag of the wake source.
// RQ3: In OFF every serial access is ignored; nothing can be programmed.
// RQ4: Host drives power-on low and button high before the OFF command.
// RQ5: In IDLE the RF section stays off while the host programs it.
// RQ6: Switch-on reset clears control logic and loads all register defaults.
// RQ7: Switch-on sets the supply-reset flag in the status register.
// RQ8: Clock output starts only after supply good and oscillator start-up.
// RQ9: Supply-reset flag clears only with supply good, oscillator up, status read.
// RQ10: Supply loss with button high and power-on low returns to OFF.
// RQ11: Sixteen-byte data buffer and eight control bytes, all read and write.
// RQ12: An eight-bit status register, separate from storage, readable serially.
// RQ13: Buffer, control and status survive active states, lost in OFF.
// RQ14: Receive modes raise interrupt at 1, 2, 4 or 12 bytes, or error.
// RQ15: Transmit mode raises interrupt at 1, 2, 4 or 12 left, or empty.
// RQ16: The threshold field does nothing in either full-duplex mode.
// RQ17: Bit 5 low limits synthesizer word to 3072..4095, high allows 0..8191.
// RQ18: Bit 4 selects 433/868 MHz band when low, 315 MHz when high.
// RQ19: Bits 3:1 pick IDLE, transmit, polling, receive, duplex master or slave.
// RQ20: Bit 0 high bypasses the buffer; modulation goes over the serial pins.
// RQ21: Undefined mode codes 100 and 110 behave as IDLE.
module transceiver_mode_control (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        power_on_input,
   input  wire logic        push_button_wake_input_n,
   input  wire logic        supply_good,
   input  wire logic        crystal_oscillator_ok,
   input  wire logic        cs,
   input  wire logic        sck,
   input  wire logic        serial_in_mod_data,
   input  wire logic [4:0]  rx_fill,
   input  wire logic [4:0]  tx_left,
   input  wire logic        rx_error,
   input  wire logic        rx_mod_data,
   input  wire logic        tx_buf_mod_data,
   output logic             serial_out_mod_data,
   output logic             irq,
   output logic             digital_supply,
   output logic             internal_supply_reset,
   output logic             clk_out_enable,
   output logic             rf_enable,
   output logic [2:0]       op_mode,
   output logic             full_duplex,
   output logic             band_select,
   output logic [12:0]      synth_word,
   output logic             transparent,
   output logic             tx_mod_data
);

   trx_pkg::pwr_state_t pwr;
   trx_pkg::pwr_state_t next_pwr;

   logic       pon_m;
   logic       pon_s;
   logic       btn_m;
   logic       btn_n_s;
   logic       sg_m;
   logic       sg_s;
   logic       osc_m;
   logic       osc_s;
   logic [7:0] buffer [`BUF_DEPTH];
   logic [7:0] ctrl [`CTRL_NUM];
   logic       flag_pwr;
   logic       flag_btn;
   logic       supply_reset_flag;
   logic       cmd_pulse;
   logic       data_pulse;
   logic [7:0] cmd;
   logic [7:0] wdata;
   logic       spi_sdo;
   logic       sdi_sync;
   logic [7:0] rdata;

   // Fill level chosen by the two threshold bits
   function automatic logic [4:0] thr_level(input logic [1:0] code);
      case (code)
         2'h0:    thr_level = `THR_L0;
         2'h1:    thr_level = `THR_L1;
         2'h2:    thr_level = `THR_L2;
         default: thr_level = `THR_L3;
      endcase
   endfunction

   // Codes with a defined meaning; the rest fall back to IDLE
   function automatic logic mode_defined(input logic [2:0] code);
      mode_defined = (code != 3'h4) && (code != 3'h6);
   endfunction

   // Default content of each control byte
   function automatic logic [7:0] ctrl_default(input int idx);
      case (idx)
         0:       ctrl_default = `OPCFG_RST;
         1:       ctrl_default = `SYN_LO_RST;
         2:       ctrl_default = `SYN_HI_RST;
         default: ctrl_default = `CTRL_RST;
      endcase
   endfunction

   // Wake pins and supply monitors come from outside: two flops each
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         {pon_m, pon_s, sg_m, sg_s, osc_m, osc_s} <= 6'h00;
         {btn_m, btn_n_s} <= 2'h3;
      end
      else
      begin
         {pon_m, pon_s} <= {power_on_input, pon_m};
         {btn_m, btn_n_s} <= {push_button_wake_input_n, btn_m};
         {sg_m, sg_s} <= {supply_good, sg_m};
         {osc_m, osc_s} <= {crystal_oscillator_ok, osc_m};
      end
   end

   // Serial port; it stays deaf unless the device is fully on
   serial_frame u_serial (
      .clk        (clk),
      .rstn       (rstn),
      .enable     (pwr == trx_pkg::PWR_FULL),
      .cs         (cs),
      .sck        (sck),
      .sdi        (serial_in_mod_data),
      .rdata      (rdata),
      .sdi_sync   (sdi_sync),
      .cmd_pulse  (cmd_pulse),
      .data_pulse (data_pulse),
      .cmd        (cmd),
      .data       (wdata),
      .sdo        (spi_sdo)
   );

   // Power sequencing terms
   wire is_on     = (pwr == trx_pkg::PWR_FULL);
   wire is_off    = (pwr == trx_pkg::PWR_OFF);
   wire wake_pon  = is_off & pon_s;                       // RQ1
   wire wake_btn  = is_off & ~btn_n_s;                    // RQ1
   wire wake      = wake_pon | wake_btn;
   wire supply_up = sg_s & osc_s;
   wire drop      = ~sg_s & btn_n_s & ~pon_s;             // RQ10
   wire cmd_op_off  = is_on & cmd_pulse & (cmd[7:6] == `CMD_OFF);
   wire stat_rd   = is_on & cmd_pulse & (cmd[7:6] == `CMD_STAT);
   wire wr_hit    = is_on & data_pulse & (cmd[7:6] == `CMD_WR); // RQ3
   wire in_buf    = ~cmd[4];
   wire in_ctrl   = cmd[4] & (cmd[3] == 1'b0);

   // Power state; the host keeps the wake pins released before OFF
   always_comb
   begin
      next_pwr = pwr;
      case (pwr)
         trx_pkg::PWR_OFF:
            if (wake)
               next_pwr = trx_pkg::PWR_RAMP;              // RQ1
         trx_pkg::PWR_RAMP:
            if (sg_s)
               next_pwr = trx_pkg::PWR_FULL;
         trx_pkg::PWR_FULL:
            if (drop | cmd_op_off)
               next_pwr = trx_pkg::PWR_OFF;               // RQ10 RQ4
         default:
            next_pwr = trx_pkg::PWR_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         pwr <= trx_pkg::PWR_OFF;
      else
         pwr <= next_pwr;
   end

   // Supply switch and internal reset follow the state
   assign digital_supply        = ~is_off;
   assign internal_supply_reset = ~is_on;                 // RQ6

   // Data buffer; contents held only while powered
   genvar gi;
   generate
      for (gi = 0; gi < `BUF_DEPTH; gi++)
      begin : g_buf
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               buffer[gi] <= `BUF_RST;
            else if (!is_on)
               buffer[gi] <= `BUF_RST;                    // RQ13
            else if (wr_hit & in_buf & (cmd[3:0] == 4'(gi)))
               buffer[gi] <= wdata;                       // RQ11
         end
      end
      // Control bank; defaults reload on every switch-on
      for (gi = 0; gi < `CTRL_NUM; gi++)
      begin : g_ctrl
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               ctrl[gi] <= ctrl_default(gi);
            else if (!is_on)
               ctrl[gi] <= ctrl_default(gi);              // RQ6 RQ13
            else if (wr_hit & in_ctrl & (cmd[2:0] == 3'(gi)))
               ctrl[gi] <= wdata;                         // RQ11
         end
      end
   endgenerate

   // Status flags; a set in the clearing cycle wins
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         flag_pwr          <= 1'b0;
         flag_btn          <= 1'b0;
         supply_reset_flag <= 1'b0;
      end
      else
      begin
         if (wake_pon)
            flag_pwr <= 1'b1;                             // RQ2
         else if (is_off | stat_rd)
            flag_pwr <= 1'b0;
         if (wake_btn)
            flag_btn <= 1'b1;                             // RQ2
         else if (is_off | stat_rd)
            flag_btn <= 1'b0;
         if (wake)
            supply_reset_flag <= 1'b1;                    // RQ7
         else if (is_off | (stat_rd & supply_up))
            supply_reset_flag <= 1'b0;                    // RQ9
      end
   end

   wire [7:0] status = {flag_pwr, flag_btn, 5'h00, supply_reset_flag}; // RQ12

   // Read data for the byte that follows the command
   assign rdata = (cmd[7:6] == `CMD_STAT) ? status :
                  in_buf  ? buffer[cmd[3:0]] :
                  in_ctrl ? ctrl[cmd[2:0]] : 8'h00;

   // operating_config decode
   wire [7:0] opcfg    = ctrl[`OPCFG_OFS];
   wire [2:0] mode_raw = opcfg[`F_OPM_MSB:`F_OPM_LSB];    // RQ19
   wire [2:0] mode_eff = mode_defined(mode_raw) ? mode_raw
                         : trx_pkg::OPM_IDLE;             // RQ21
   wire mode_tx  = (mode_eff == trx_pkg::OPM_TX);
   wire mode_rx  = (mode_eff == trx_pkg::OPM_RX) | (mode_eff == trx_pkg::OPM_POLL);
   wire mode_fd  = (mode_eff == trx_pkg::OPM_FDM) | (mode_eff == trx_pkg::OPM_FDS);
   wire [4:0] thr = thr_level(opcfg[`F_THR_MSB:`F_THR_LSB]);
   wire transp   = opcfg[`F_TRANSP];

   // Threshold only counts in plain receive or transmit modes
   wire rx_hit = is_on & mode_rx & ((rx_fill >= thr) | rx_error);          // RQ14
   wire tx_hit = is_on & mode_tx & ((tx_left == thr) | (tx_left == 5'h00)); // RQ15

   // Synthesizer word; narrow range pins the top bits to the base
   wire [12:0] word_wide = {ctrl[`SYN_HI_OFS][7:2], ctrl[`SYN_LO_OFS][7:1]};
   wire [12:0] word_narr = `SYN_BASE | {3'h0, word_wide[9:0]};
   wire [12:0] word_sel  = opcfg[`F_RANGE] ? word_wide : word_narr;   // RQ17

   // Clock output enable gated by both clock bits as well
   wire clk_bits = ctrl[`SYN_HI_OFS][`F_CLK_EN] & ctrl[`SYN_HI_OFS][`F_CLK_ON];

   // Interrupt level; a status read clears it, a new event wins
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         irq <= 1'b0;
      else if (wake | rx_hit | tx_hit)
         irq <= 1'b1;                                     // RQ2 RQ14 RQ15 RQ16
      else if (is_off | stat_rd)
         irq <= 1'b0;
   end

   // Registered mode and RF outputs
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         op_mode        <= trx_pkg::OPM_IDLE;
         rf_enable      <= 1'b0;
         full_duplex    <= 1'b0;
         band_select    <= 1'b0;
         synth_word     <= 13'h0000;
         transparent    <= 1'b0;
         clk_out_enable <= 1'b0;
      end
      else
      begin
         op_mode        <= is_on ? mode_eff : trx_pkg::OPM_IDLE;
         rf_enable      <= is_on & (mode_eff != trx_pkg::OPM_IDLE); // RQ5
         full_duplex    <= is_on & mode_fd;
         band_select    <= opcfg[`F_BAND];                 // RQ18
         synth_word     <= word_sel;
         transparent    <= is_on & transp;
         clk_out_enable <= is_on & supply_up & clk_bits;   // RQ8
      end
   end

   // Transparent mode routes modulation around the buffer
   wire tx_src  = transp ? sdi_sync : tx_buf_mod_data;     // RQ20
   wire out_src = (is_on & transp & (mode_rx | mode_fd)) ? rx_mod_data : spi_sdo;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_mod_data         <= 1'b0;
         serial_out_mod_data <= 1'b0;
      end
      else
      begin
         tx_mod_data         <= tx_src;                    // RQ20
         serial_out_mod_data <= out_src;
      end
   end

   // Checks, all in the core clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   wake_to_ramp_a: assert property (wake |=> pwr == trx_pkg::PWR_RAMP) // RQ1
      else $error("wake did not leave OFF");
   wake_flag_a: assert property (wake_pon |=> irq && status[`ST_PWR]) // RQ2
      else $error("wake did not raise irq and flag");
   off_deaf_a: assert property (!is_on |=> opcfg == `OPCFG_RST) // RQ3
      else $error("config changed while not on");
   idle_rf_a: assert property (mode_eff == trx_pkg::OPM_IDLE |=> !rf_enable) // RQ5
      else $error("rf enabled in idle");
   srst_set_a: assert property (wake |=> supply_reset_flag) // RQ7
      else $error("supply reset flag not set");
   clk_out_a: assert property (clk_out_enable |-> $past(supply_up)) // RQ8
      else $error("clock out before supply and oscillator");
   srst_hold_a: assert property (supply_reset_flag && !supply_up && is_on
                                 |=> supply_reset_flag) // RQ9
      else $error("supply reset flag cleared early");
   drop_off_a: assert property (is_on && drop |=> is_off) // RQ10
      else $error("supply loss did not return to OFF");
   undef_mode_a: assert property (is_on && !mode_defined(mode_raw)
                                  |=> op_mode == trx_pkg::OPM_IDLE && !rf_enable) // RQ21
      else $error("undefined mode not treated as idle");
   narrow_word_a: assert property (!opcfg[`F_RANGE] |=> synth_word >= 13'h0c00
                                   && synth_word <= 13'h0fff) // RQ17
      else $error("synth word outside narrow range");

   btn_wake_c: cover property (wake_btn ##1 pwr == trx_pkg::PWR_RAMP);
   stat_rd_c: cover property (stat_rd && supply_reset_flag && supply_up);
   off_cmd_c: cover property (cmd_op_off ##1 is_off);
   rx_thr_c: cover property (rx_hit && !irq ##1 irq);

endmodule // transceiver_mode_control

// >>> trx_params.svh
// Offsets, field positions, reset values and counts of the mode control block
`ifndef TRX_PARAMS_SVH
`define TRX_PARAMS_SVH

// Register map: buffer at 0x00..0x0f, control bank from CTRL_BASE
`define BUF_DEPTH     16
`define CTRL_NUM      8
`define CTRL_BASE     5'h10
`define OPCFG_OFS     3'h0
`define SYN_LO_OFS    3'h1
`define SYN_HI_OFS    3'h2

// Reset values
`define OPCFG_RST     8'h80
`define SYN_LO_RST    8'ha8
`define SYN_HI_RST    8'h7b
`define CTRL_RST      8'h00
`define BUF_RST       8'h00

// Fields of operating_config
`define F_THR_MSB     7
`define F_THR_LSB     6
`define F_RANGE       5
`define F_BAND        4
`define F_OPM_MSB     3
`define F_OPM_LSB     1
`define F_TRANSP      0

// Clock output control bits in the upper frequency register
`define F_CLK_EN      1
`define F_CLK_ON      0

// Status register bits
`define ST_PWR        7
`define ST_BTN        6
`define ST_SRST       0

// Serial command codes in command bits 7:6
`define CMD_RD        2'h0
`define CMD_WR        2'h1
`define CMD_STAT      2'h2
`define CMD_OFF       2'h3

// Interrupt fill levels
`define THR_L0        5'h01
`define THR_L1        5'h02
`define THR_L2        5'h04
`define THR_L3        5'h0c

// Synthesizer word base of the narrow range
`define SYN_BASE      13'h0c00

// Bit count of the last bit of a serial byte
`define FRAME_LAST    3'h7

`endif

// >>> trx_pkg.sv
// Types shared by the mode control block
package trx_pkg;

   // Power states, Gray along OFF -> RAMP -> ON
   typedef enum logic [1:0] {
      PWR_OFF  = 2'h0,
      PWR_RAMP = 2'h1,
      PWR_FULL = 2'h3
   } pwr_state_t;

   // Operating mode codes of operating_config bits 3:1
   typedef enum logic [2:0] {
      OPM_IDLE = 3'h0,
      OPM_TX   = 3'h1,
      OPM_POLL = 3'h2,
      OPM_RX   = 3'h3,
      OPM_FDM  = 3'h5,
      OPM_FDS  = 3'h7
   } op_mode_t;

endpackage

// >>> serial_frame.sv
// Four-wire serial port: pin synchronisers, command and data byte framing
`timescale 1ns/1ps
`include "trx_params.svh"

module serial_frame (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       enable,
   input  wire logic       cs,
   input  wire logic       sck,
   input  wire logic       sdi,
   input  wire logic [7:0] rdata,
   output logic            sdi_sync,
   output logic            cmd_pulse,
   output logic            data_pulse,
   output logic [7:0]      cmd,
   output logic [7:0]      data,
   output logic            sdo
);

   logic       cs_m;
   logic       cs_s;
   logic       sck_m;
   logic       sck_s;
   logic       sck_d;
   logic       sdi_m;
   logic       sdi_s;
   logic [2:0] cnt;
   logic       byte1;
   logic [6:0] sh;
   logic [7:0] osh;

   // Two flops on every pin; the first is read by nothing else
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         {cs_m, cs_s, sck_m, sck_s, sck_d, sdi_m, sdi_s} <= 7'h00;
      end
      else
      begin
         {cs_m, cs_s} <= {cs, cs_m};
         {sck_m, sck_s, sck_d} <= {sck, sck_m, sck_s};
         {sdi_m, sdi_s} <= {sdi, sdi_m};
      end
   end

   // Edges of the sampled serial clock, only inside a frame
   wire active    = cs_s & enable;
   wire sck_rise  = active & sck_s & ~sck_d;
   wire sck_fall  = active & ~sck_s & sck_d;
   wire byte_done = sck_rise & (cnt == `FRAME_LAST);

   assign sdi_sync = sdi_s;
   assign sdo      = osh[7];

   // Input shifter; frame restarts whenever select drops
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt   <= 3'h0;
         byte1 <= 1'b0;
         sh    <= 7'h00;
      end
      else if (!active)
      begin
         cnt   <= 3'h0;
         byte1 <= 1'b0;
      end
      else if (sck_rise)
      begin
         sh  <= {sh[5:0], sdi_s};
         cnt <= cnt + 3'h1;
         if (byte_done)
            byte1 <= 1'b1;
      end
   end

   // Byte strobes; a third and later byte repeats the data strobe
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cmd_pulse  <= 1'b0;
         data_pulse <= 1'b0;
         cmd        <= 8'h00;
         data       <= 8'h00;
      end
      else
      begin
         cmd_pulse  <= byte_done & ~byte1;
         data_pulse <= byte_done & byte1;
         if (byte_done & ~byte1)
            cmd <= {sh, sdi_s};
         if (byte_done & byte1)
            data <= {sh, sdi_s};
      end
   end

   // Read shifter; the fall right after the command byte must not shift
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         osh <= 8'h00;
      else if (cmd_pulse)
         osh <= rdata;
      else if (sck_fall & byte1 & (cnt != 3'h0))
         osh <= {osh[6:0], 1'b0};
   end

endmodule // serial_frame

// >>> serial_host.sv
// Host model that drives the four-wire serial port one frame at a time
`timescale 1ns/1ps

module serial_host (
   input  wire logic clk,
   input  wire logic sdo,
   output logic      cs,
   output logic      sck,
   output logic      sdi
);
   // Idle lines at time zero
   initial
   begin
      cs = 1'b0;
      sck = 1'b0;
      sdi = 1'b0;
   end

   // Frame: cs high, n bits MSB first; sck held 4 clk a phase
   // Read data is taken just before each sck fall, while it still stands
   task automatic xfer(input logic [7:0] c, input logic [7:0] d, input int n,
                       output logic [7:0] q);
      logic [15:0] w;
      w = {c, d};
      q = 8'h00;
      @(posedge clk);
      cs <= 1'b1;
      for (int i = 15; i > 15 - n; i--)
      begin
         sdi <= w[i];
         repeat (4) @(posedge clk);
         sck <= 1'b1;
         repeat (3) @(posedge clk);
         @(negedge clk);
         q = {q[6:0], sdo};
         @(posedge clk);
         sck <= 1'b0;
      end
      repeat (4) @(posedge clk);
      cs <= 1'b0;
      sdi <= ~sdi; // Released line must not look like data
      repeat (4) @(posedge clk);
   endtask
endmodule // serial_host

// >>> transceiver_mode_control_tb_top.sv
// Self-checking bench of the transceiver mode control block
`timescale 1ns/1ps
`include "trx_params.svh"

module transceiver_mode_control_tb_top;
   logic        clk, rstn, cs, sck, serial_in_mod_data, serial_out_mod_data;
   logic        power_on_input, push_button_wake_input_n, supply_good;
   logic        crystal_oscillator_ok, rx_error, rx_mod_data, tx_buf_mod_data;
   logic [4:0]  rx_fill, tx_left;
   logic        irq, digital_supply, internal_supply_reset, clk_out_enable;
   logic        rf_enable, full_duplex, band_select, transparent, tx_mod_data;
   logic [2:0]  op_mode;
   logic [12:0] synth_word;
   logic [7:0]  q;
   int          error_cnt;
   int          checked;

   transceiver_mode_control dut (
      .clk, .rstn, .power_on_input, .push_button_wake_input_n, .supply_good,
      .crystal_oscillator_ok, .cs, .sck, .serial_in_mod_data, .rx_fill, .tx_left,
      .rx_error, .rx_mod_data, .tx_buf_mod_data, .serial_out_mod_data, .irq,
      .digital_supply, .internal_supply_reset, .clk_out_enable, .rf_enable,
      .op_mode, .full_duplex, .band_select, .synth_word, .transparent, .tx_mod_data
   );

   serial_host host (
      .clk,
      .sdo (serial_out_mod_data),
      .cs,
      .sck,
      .sdi (serial_in_mod_data)
   );

   task automatic report_and_stop;
      $display("errors %0d of %0d checks", error_cnt, checked);
      if (error_cnt == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD %0t %s: got %h want %h", $time, m, got, exp);
      end
   endtask

   // Step past the edge so registered outputs have settled
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      host.xfer({`CMD_WR, 1'b0, a}, d, 16, q);
      tick(2);
   endtask

   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      host.xfer({`CMD_RD, 1'b0, a}, 8'h00, 16, q);
      chk(q, e, "read data");
   endtask

   task automatic st(input logic [7:0] e);
      host.xfer({`CMD_STAT, 6'h00}, 8'h00, 16, q);
      chk(q, e, "status");
   endtask

   // Bounded wait for the ON state
   task automatic wait_on;
      for (int i = 0; i < 40 && internal_supply_reset !== 1'b0; i++)
         @(posedge clk);
      tick(1);
      chk(internal_supply_reset, 1'b0, "never came up");
   endtask

   task automatic t_reset;
      tick(1);
      chk(digital_supply, 1'b0, "supply on in reset");
      chk(internal_supply_reset, 1'b1, "internal reset low");
      rd(`CTRL_BASE, 8'h00);
   endtask

   // Button wake with a slow oscillator: flag outlives the first read
   task automatic t_button;
      @(posedge clk);
      crystal_oscillator_ok <= 1'b0;
      push_button_wake_input_n <= 1'b0;
      tick(6);
      chk(irq, 1'b1, "wake irq");
      chk(digital_supply, 1'b1, "no wake");
      wait_on();
      chk(clk_out_enable, 1'b0, "clock too early");
      @(posedge clk);
      push_button_wake_input_n <= 1'b1;
      st(8'h41);
      tick(1);
      chk(irq, 1'b0, "irq not cleared");
      st(8'h01);
      @(posedge clk);
      crystal_oscillator_ok <= 1'b1;
      tick(6);
      chk(clk_out_enable, 1'b1, "clock missing");
      st(8'h01);
      st(8'h00);
   endtask

   task automatic t_regs;
      rd(`CTRL_BASE, `OPCFG_RST);
      rd(5'h11, `SYN_LO_RST);
      chk(synth_word, 13'h0f54, "default word");
      chk(band_select, 1'b0, "default band");
      wr(5'h12, 8'h83);
      chk(synth_word, 13'h0c54, "narrow word");
      wr(`CTRL_BASE, 8'hb0);
      chk(synth_word, 13'h1054, "wide word");
      chk(band_select, 1'b1, "band");
      wr(5'h0f, 8'ha5);
      wr(5'h17, 8'h3c);
      rd(5'h0f, 8'ha5);
      rd(5'h17, 8'h3c);
      rd(5'h18, 8'h00);
   endtask

   task automatic t_modes;
      logic [2:0] e;
      for (int m = 0; m < 8; m++)
      begin
         e = (m == 4 || m == 6) ? 3'h0 : 3'(m);
         wr(`CTRL_BASE, {4'h8, 3'(m), 1'b0});
         chk(op_mode, e, "mode");
         chk(full_duplex, m == 5 || m == 7, "duplex");
         chk(rf_enable, e != 3'h0, "rf enable");
      end
   endtask

   // One interrupt case, then inputs back to quiet and a clearing read
   task automatic irq_case(input logic [7:0] c, input logic [4:0] f, input logic [4:0] l,
                           input logic er, input logic e);
      wr(`CTRL_BASE, c);
      @(posedge clk);
      rx_fill <= f;
      tx_left <= l;
      rx_error <= er;
      tick(4);
      chk(irq, e, "irq level");
      @(posedge clk);
      rx_fill <= 5'h00;
      tx_left <= 5'h05;
      rx_error <= 1'b0;
      host.xfer({`CMD_STAT, 6'h00}, 8'h00, 16, q);
   endtask

   task automatic t_irq;
      irq_case(8'hc6, 5'h0b, 5'h05, 1'b0, 1'b0);
      irq_case(8'hc6, 5'h0c, 5'h05, 1'b0, 1'b1);
      irq_case(8'hc6, 5'h00, 5'h05, 1'b1, 1'b1);
      irq_case(8'h04, 5'h01, 5'h05, 1'b0, 1'b1);
      irq_case(8'h82, 5'h00, 5'h03, 1'b0, 1'b0);
      irq_case(8'h82, 5'h00, 5'h04, 1'b0, 1'b1);
      irq_case(8'h02, 5'h00, 5'h02, 1'b0, 1'b0);
      irq_case(8'h42, 5'h00, 5'h02, 1'b0, 1'b1);
      irq_case(8'h02, 5'h00, 5'h00, 1'b0, 1'b1);
      irq_case(8'h0a, 5'h0c, 5'h00, 1'b1, 1'b0);
      irq_case(8'h0e, 5'h0c, 5'h00, 1'b1, 1'b0);
   endtask

   // Both modulation streams bypass the buffer, then the transmit stream returns to it
   task automatic t_transp;
      wr(`CTRL_BASE, 8'h87); // Receive mode, so the rx stream owns the output pin
      chk(transparent, 1'b1, "transparent");
      for (int v = 0; v < 2; v++)
      begin
         @(posedge clk);
         host.sdi <= v[0];
         tx_buf_mod_data <= ~v[0];
         rx_mod_data <= ~v[0];
         tick(6);
         chk(tx_mod_data, v[0], "tx bypass");
         chk(serial_out_mod_data, !v[0], "rx bypass");
      end
      wr(`CTRL_BASE, 8'h80);
      @(posedge clk);
      host.sdi <= 1'b0;
      tx_buf_mod_data <= 1'b1;
      tick(6);
      chk(tx_mod_data, 1'b1, "buffer path");
   endtask

   // OFF command loses all storage; power-on pin wakes again
   task automatic t_off;
      host.xfer({`CMD_OFF, 6'h00}, 8'h00, 8, q);
      tick(2);
      chk(digital_supply, 1'b0, "off command");
      @(posedge clk);
      power_on_input <= 1'b1;
      wait_on();
      @(posedge clk);
      power_on_input <= 1'b0;
      rd(5'h0f, `BUF_RST);
      rd(5'h17, `CTRL_RST);
      rd(`CTRL_BASE, `OPCFG_RST);
      st(8'h81);
   endtask

   task automatic t_drop;
      @(posedge clk);
      supply_good <= 1'b0;
      tick(6);
      chk(digital_supply, 1'b0, "supply loss");
      @(posedge clk);
      supply_good <= 1'b1;
   endtask

   // Core clock, 100 ns
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Main sequence
   initial
   begin
      error_cnt = 0;
      checked = 0;
      rstn = 1'b0;
      power_on_input = 1'b0;
      push_button_wake_input_n = 1'b1;
      supply_good = 1'b1;
      crystal_oscillator_ok = 1'b1;
      rx_fill = 5'h00;
      tx_left = 5'h05;
      rx_error = 1'b0;
      rx_mod_data = 1'b0;
      tx_buf_mod_data = 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      t_reset();
      t_button();
      t_regs();
      t_modes();
      t_irq();
      t_transp();
      t_off();
      t_drop();
      report_and_stop();
   end

   // Hang guard, well above the expected 7100 clk
   initial
   begin
      #2000000;
      error_cnt++;
      report_and_stop();
   end
endmodule // transceiver_mode_control_tb_top
